/* srp_pkg.sv */
// shared constants, types and helpers of the serial register protocol
package srp_pkg;
  localparam int          CLK_MHZ     = 100;
  localparam int          TIMEOUT_MS  = 360;
  localparam logic [31:0] TIMEOUT_DEF = 32'(TIMEOUT_MS * 1000 * CLK_MHZ);
  localparam logic [7:0]  ECHO_CMD    = 8'hC1;
  localparam logic [7:0]  ECHO_ADDR   = 8'hC2;
  localparam logic [7:0]  ACK         = 8'h41;
  localparam logic [7:0]  NAK         = 8'h4E;
  localparam logic [7:0]  CRC_POLY    = 8'h31;
  localparam logic [7:0]  CRC_INIT    = 8'h00;
  localparam logic [1:0]  OP_READ     = 2'h0;
  localparam logic [1:0]  OP_WRITE    = 2'h2;
  localparam int          OP_LSB      = 6;
  localparam int          LEN_LSB     = 4;
  localparam int          FIFO_W      = 8;
  localparam int          FIFO_D      = 16;

  typedef enum logic [7:0] {
    ST_IDLE  = 8'h01,
    ST_ADDR  = 8'h02,
    ST_WDATA = 8'h04,
    ST_WCRC  = 8'h08,
    ST_WSYNC = 8'h10,
    ST_RSYNC = 8'h20,
    ST_RDATA = 8'h40,
    ST_RCRC  = 8'h80
  } srp_state_t;

  typedef struct packed {
    logic        write;
    logic [1:0]  len;
    logic [11:0] addr;
  } srp_cmd_t;

  typedef struct packed {
    logic sclk;
    logic ss_n;
    logic mosi;
  } srp_pins_t;

  // msb first, register starts from CRC_INIT
  function automatic logic [7:0] crc8(input logic [7:0] crc,
                                      input logic [7:0] data);
    logic [7:0] c;
    c = crc ^ data;
    for (int i = 0; i < 8; i++) begin
      c = c[7] ? ((c << 1) ^ CRC_POLY) : (c << 1);
    end
    return c;
  endfunction : crc8

  function automatic logic [3:0] len_bytes(input logic [1:0] code);
    return 4'(4'h1 << code);
  endfunction : len_bytes
endpackage : srp_pkg

/* srp_fifo.sv */
// read-data fifo between register backend and serial answer path
`timescale 1ns/1ps
module srp_fifo #(
  parameter int W = 8,
  parameter int D = 16
) (
  input  wire logic         clk,
  input  wire logic         rst_n,
  input  wire logic         flush,
  input  wire logic         in_valid,
  output logic              in_ready,
  input  wire logic [W-1:0] in_data,
  output logic              out_valid,
  input  wire logic         out_ready,
  output logic [W-1:0]      out_data
);
  localparam int AW = $clog2(D);
  logic [W-1:0]  mem [D];
  logic [AW-1:0] wr_q;
  logic [AW-1:0] rd_q;
  logic [AW:0]   cnt_q;
  logic [AW:0]   cnt_d;
  logic          push;
  logic          pop;

  assign push      = in_valid & in_ready;
  assign pop       = out_valid & out_ready;
  assign out_valid = (cnt_q != '0);
  assign out_data  = mem[rd_q];

  always_comb begin
    cnt_d = cnt_q;
    if (push & ~pop) begin
      cnt_d = cnt_q + 1'b1;
    end else if (pop & ~push) begin
      cnt_d = cnt_q - 1'b1;
    end
  end

  always_ff @(posedge clk) begin
    if (!rst_n || flush) begin
      wr_q     <= '0;
      rd_q     <= '0;
      cnt_q    <= '0;
      in_ready <= 1'b1;
    end else begin
      if (push) begin
        wr_q <= wr_q + 1'b1;
      end
      if (pop) begin
        rd_q <= rd_q + 1'b1;
      end
      cnt_q    <= cnt_d;
      // registered full flag keeps the backend ready off the comb path
      in_ready <= (cnt_d != (AW+1)'(D));
    end
  end

  always_ff @(posedge clk) begin
    if (push) begin
      mem[wr_q] <= in_data;
    end
  end
endmodule : srp_fifo

/* srp_top.sv */
// serial register command protocol, device end
// Function
// - command byte bits 7:6: 00 read, 10 write, 01 and 11 reserved.
// - bits 5:4 give payload length of 1, 2, 4 or 8 bytes.
// - 12-bit address: high nibble in byte one, low byte in byte two.
// - device answers 0xC1 to command byte and 0xC2 to address byte.
// - write payload arrives lsb first; payload and crc bytes answered 0x41.
// - after write, dummies get 0x4E while busy, then 0x41; host waits.
// - timeout count starts after eighth clock of the command byte.
// - timeout count stops and clears after the last byte completes.
// - count above limit drops partial transaction and returns to idle.
// - limit after reset equals 360 ms.
// - crc enable adds one crc byte; host sends on write, device on read.
// - crc8, polynomial x^8+x^5+x^4+1, command through last data, no sync.
// - write with wrong crc is discarded, register left unchanged.
// - transaction length follows only length field and crc enable; reserved codes ignore both and end after command, address and one 0x41.
// - surplus bytes ignored while busy, else taken as a new command.
// - too few bytes: wait for timeout, then drop and reinitialise.
// - device only sets processing-done flag; host clears it harmlessly.
// - multi-byte values return least significant byte first.
// - read: 0x4E while busy, 0x41, payload lsb first, optional crc.
// - after final acknowledge a new command is accepted without select.
`timescale 1ns/1ps
module srp_top #(
  parameter logic [31:0] TIMEOUT_CYCLES = srp_pkg::TIMEOUT_DEF
) (
  input  wire logic              CLOCK,
  input  wire logic              RESET_N,
  input  wire logic              SCLK,
  input  wire logic              SS_N,
  input  wire logic              MOSI,
  output logic                   MISO,
  output logic                   MISO_OE,
  input  wire logic              CRC_CHECK_ENABLE,
  input  wire logic [31:0]       COMM_TIMEOUT_LIMIT,
  input  wire logic              COMM_TIMEOUT_LOAD,
  output logic                   REQ_VALID,
  output srp_pkg::srp_cmd_t      REQ_CMD,
  output logic [63:0]            WR_DATA,
  input  wire logic              BACK_DONE,
  input  wire logic              RD_VALID,
  output logic                   RD_READY,
  input  wire logic [7:0]        RD_DATA,
  output logic                   BUSY,
  output logic                   TIMEOUT_EVENT,
  output logic                   CRC_ERROR,
  input  wire logic              CYCLE_END,
  input  wire logic              FLAG_CLEAR,
  output logic                   PROCESSING_CYCLE_DONE_FLAG
);
  srp_pkg::srp_pins_t  s1_q;
  srp_pkg::srp_pins_t  s2_q;
  srp_pkg::srp_pins_t  s3_q;
  srp_pkg::srp_state_t state_q;
  srp_pkg::srp_cmd_t   cmd_q;
  logic [2:0]          bit_q;
  logic [7:0]          rx_q;
  logic [7:0]          byte_q;
  logic                byte_done_q;
  logic [2:0]          cnt_q;
  logic [7:0]          crc_q;
  logic                crc_on_q;
  logic                done_q;
  logic                ack_q;
  logic [7:0]          tx_q;
  logic [31:0]         limit_q;
  logic [31:0]         to_cnt_q;
  logic                abort;
  logic                rise;
  logic                fall;
  logic                last;
  logic                pop;
  logic                flush;
  logic                fifo_valid;
  logic [7:0]          fifo_data;
  logic [1:0]          op;
  logic [7:0]          crc_next;

  // pins cross into CLOCK through two flops; third stage finds edges
  always_ff @(posedge CLOCK) begin
    if (!RESET_N) begin
      s1_q <= '{sclk: 1'b0, ss_n: 1'b1, mosi: 1'b0};
      s2_q <= '{sclk: 1'b0, ss_n: 1'b1, mosi: 1'b0};
      s3_q <= '{sclk: 1'b0, ss_n: 1'b1, mosi: 1'b0};
    end else begin
      s1_q <= '{sclk: SCLK, ss_n: SS_N, mosi: MOSI};
      s2_q <= s1_q;
      s3_q <= s2_q;
    end
  end

  assign rise = s2_q.sclk & ~s3_q.sclk & ~s2_q.ss_n;
  assign fall = ~s2_q.sclk & s3_q.sclk & ~s2_q.ss_n;

  // mode 0 receive: sample on rising edge, msb first
  always_ff @(posedge CLOCK) begin
    if (!RESET_N || abort || s2_q.ss_n) begin
      bit_q       <= 3'h0;
      rx_q        <= 8'h00;
      byte_q      <= 8'h00;
      byte_done_q <= 1'b0;
    end else begin
      byte_done_q <= rise && (bit_q == 3'h7);
      if (rise) begin
        bit_q <= bit_q + 3'h1;
        rx_q  <= {rx_q[6:0], s2_q.mosi};
        if (bit_q == 3'h7) begin
          byte_q <= {rx_q[6:0], s2_q.mosi};
        end
      end
    end
  end

  always_ff @(posedge CLOCK) begin
    if (!RESET_N) begin
      MISO_OE <= 1'b0;
    end else begin
      MISO_OE <= ~s2_q.ss_n;
    end
  end

  assign MISO     = tx_q[7];
  assign op       = byte_q[srp_pkg::OP_LSB +: 2];
  assign crc_next = srp_pkg::crc8(crc_q, byte_q);
  assign last     = (4'(cnt_q) + 4'h1) == srp_pkg::len_bytes(cmd_q.len);
  assign pop      = byte_done_q &&
                    ((state_q == srp_pkg::ST_RSYNC && ack_q) ||
                     (state_q == srp_pkg::ST_RDATA && !last));
  assign flush    = abort ||
                    (byte_done_q && state_q == srp_pkg::ST_ADDR);

  srp_fifo #(
    .W (srp_pkg::FIFO_W),
    .D (srp_pkg::FIFO_D)
  ) u_fifo (
    .clk       (CLOCK),
    .rst_n     (RESET_N),
    .flush     (flush),
    .in_valid  (RD_VALID),
    .in_ready  (RD_READY),
    .in_data   (RD_DATA),
    .out_valid (fifo_valid),
    .out_ready (pop),
    .out_data  (fifo_data)
  );

  // timeout: runs from command byte to final byte, reloadable limit
  always_ff @(posedge CLOCK) begin
    if (!RESET_N) begin
      limit_q <= TIMEOUT_CYCLES;
    end else if (COMM_TIMEOUT_LOAD) begin
      limit_q <= COMM_TIMEOUT_LIMIT;
    end
  end

  // abort clears the count too, so the timeout event pulses only once
  always_ff @(posedge CLOCK) begin
    if (!RESET_N || abort || state_q == srp_pkg::ST_IDLE) begin
      to_cnt_q <= 32'h0;
    end else begin
      to_cnt_q <= to_cnt_q + 32'h1;
    end
  end

  assign abort = (to_cnt_q > limit_q);

  always_ff @(posedge CLOCK) begin
    if (!RESET_N) begin
      TIMEOUT_EVENT <= 1'b0;
      BUSY          <= 1'b0;
    end else begin
      TIMEOUT_EVENT <= abort;
      BUSY          <= (state_q != srp_pkg::ST_IDLE);
    end
  end

  // set wins over clear; clearing never touches processing
  always_ff @(posedge CLOCK) begin
    if (!RESET_N) begin
      PROCESSING_CYCLE_DONE_FLAG <= 1'b0;
    end else if (CYCLE_END) begin
      PROCESSING_CYCLE_DONE_FLAG <= 1'b1;
    end else if (FLAG_CLEAR) begin
      PROCESSING_CYCLE_DONE_FLAG <= 1'b0;
    end
  end

  // byte sequencer; answer for the next byte is loaded when one ends
  always_ff @(posedge CLOCK) begin
    if (!RESET_N || abort) begin
      state_q   <= srp_pkg::ST_IDLE;
      tx_q      <= srp_pkg::ECHO_CMD;
      cmd_q     <= '0;
      cnt_q     <= 3'h0;
      crc_q     <= srp_pkg::CRC_INIT;
      crc_on_q  <= 1'b0;
      done_q    <= 1'b0;
      ack_q     <= 1'b0;
      WR_DATA   <= 64'h0;
      REQ_VALID <= 1'b0;
      CRC_ERROR <= 1'b0;
    end else begin
      REQ_VALID <= 1'b0;
      CRC_ERROR <= 1'b0;
      if (BACK_DONE) begin
        done_q <= 1'b1;
      end
      if (fall && bit_q != 3'h0) begin
        tx_q <= {tx_q[6:0], 1'b0};
      end
      if (byte_done_q) begin
        unique case (state_q)
          srp_pkg::ST_IDLE: begin
            cmd_q.write <= (op == srp_pkg::OP_WRITE);
            cmd_q.len   <= byte_q[srp_pkg::LEN_LSB +: 2];
            cmd_q.addr  <= {byte_q[3:0], 8'h00};
            crc_on_q    <= CRC_CHECK_ENABLE;
            crc_q       <= srp_pkg::crc8(srp_pkg::CRC_INIT, byte_q);
            ack_q       <= (op != srp_pkg::OP_READ) &&
                           (op != srp_pkg::OP_WRITE);
            cnt_q       <= 3'h0;
            WR_DATA     <= 64'h0;
            tx_q        <= srp_pkg::ECHO_ADDR;
            state_q     <= srp_pkg::ST_ADDR;
          end
          srp_pkg::ST_ADDR: begin
            cmd_q.addr[7:0] <= byte_q;
            crc_q           <= crc_next;
            if (ack_q) begin
              // reserved code: acknowledge once and finish
              done_q  <= 1'b1;
              tx_q    <= srp_pkg::ACK;
              state_q <= srp_pkg::ST_WSYNC;
            end else if (cmd_q.write) begin
              tx_q    <= srp_pkg::ACK;
              state_q <= srp_pkg::ST_WDATA;
            end else begin
              REQ_VALID <= 1'b1;
              done_q    <= BACK_DONE;
              tx_q      <= srp_pkg::NAK;
              state_q   <= srp_pkg::ST_RSYNC;
            end
          end
          srp_pkg::ST_WDATA: begin
            WR_DATA[{cnt_q, 3'h0} +: 8] <= byte_q;
            crc_q <= crc_next;
            cnt_q <= cnt_q + 3'h1;
            if (!last) begin
              tx_q <= srp_pkg::ACK;
            end else if (crc_on_q) begin
              tx_q    <= srp_pkg::ACK;
              state_q <= srp_pkg::ST_WCRC;
            end else begin
              REQ_VALID <= 1'b1;
              done_q    <= BACK_DONE;
              ack_q     <= 1'b0;
              tx_q      <= srp_pkg::NAK;
              state_q   <= srp_pkg::ST_WSYNC;
            end
          end
          srp_pkg::ST_WCRC: begin
            state_q <= srp_pkg::ST_WSYNC;
            if (byte_q == crc_q) begin
              REQ_VALID <= 1'b1;
              done_q    <= BACK_DONE;
              ack_q     <= 1'b0;
              tx_q      <= srp_pkg::NAK;
            end else begin
              CRC_ERROR <= 1'b1;
              done_q    <= 1'b1;
              ack_q     <= 1'b1;
              tx_q      <= srp_pkg::ACK;
            end
          end
          srp_pkg::ST_WSYNC: begin
            if (ack_q) begin
              state_q <= srp_pkg::ST_IDLE;
              tx_q    <= srp_pkg::ECHO_CMD;
            end else begin
              // bytes while busy are swallowed
              ack_q <= done_q;
              tx_q  <= done_q ? srp_pkg::ACK : srp_pkg::NAK;
            end
          end
          srp_pkg::ST_RSYNC: begin
            if (ack_q) begin
              tx_q    <= fifo_data;
              crc_q   <= srp_pkg::crc8(crc_q, fifo_data);
              cnt_q   <= 3'h0;
              state_q <= srp_pkg::ST_RDATA;
            end else begin
              // data counted complete only once backend reports done
              ack_q <= done_q && fifo_valid;
              tx_q  <= (done_q && fifo_valid) ? srp_pkg::ACK
                                              : srp_pkg::NAK;
            end
          end
          srp_pkg::ST_RDATA: begin
            cnt_q <= cnt_q + 3'h1;
            if (!last) begin
              tx_q  <= fifo_data;
              crc_q <= srp_pkg::crc8(crc_q, fifo_data);
            end else if (crc_on_q) begin
              tx_q    <= crc_q;
              state_q <= srp_pkg::ST_RCRC;
            end else begin
              tx_q    <= srp_pkg::ECHO_CMD;
              state_q <= srp_pkg::ST_IDLE;
            end
          end
          srp_pkg::ST_RCRC: begin
            tx_q    <= srp_pkg::ECHO_CMD;
            state_q <= srp_pkg::ST_IDLE;
          end
        endcase
      end
    end
  end

  assign REQ_CMD = cmd_q;
endmodule : srp_top

/* srp_props.sv */
// checker for the serial register protocol device ports
`timescale 1ns/1ps
module srp_props #(
  parameter logic [31:0] TIMEOUT_CYCLES = srp_pkg::TIMEOUT_DEF
) (
  input wire logic              CLOCK,
  input wire logic              RESET_N,
  input wire logic [31:0]       COMM_TIMEOUT_LIMIT,
  input wire logic              COMM_TIMEOUT_LOAD,
  input wire logic              REQ_VALID,
  input wire srp_pkg::srp_cmd_t REQ_CMD,
  input wire logic [63:0]       WR_DATA,
  input wire logic              BACK_DONE,
  input wire logic              BUSY,
  input wire logic              TIMEOUT_EVENT,
  input wire logic              CRC_ERROR,
  input wire logic              CYCLE_END,
  input wire logic              FLAG_CLEAR,
  input wire logic              PROCESSING_CYCLE_DONE_FLAG
);
  default clocking cb @(posedge CLOCK);
  endclocking
  default disable iff (!RESET_N);
  logic [31:0] lim_q;
  logic [31:0] run_q;
  logic        done;
  assign done = PROCESSING_CYCLE_DONE_FLAG;
  always_ff @(posedge CLOCK) begin
    if (!RESET_N) lim_q <= TIMEOUT_CYCLES;
    else if (COMM_TIMEOUT_LOAD) lim_q <= COMM_TIMEOUT_LIMIT;
  end
  // busy run length stands in for the hidden timeout counter
  always_ff @(posedge CLOCK) begin
    if (!RESET_N || !BUSY) run_q <= 32'h0000_0000;
    else run_q <= run_q + 32'h0000_0001;
  end
  flag_set_a: assert property (CYCLE_END |=> done)
    else $error("flag not set");
  flag_clear_a: assert property (FLAG_CLEAR && !CYCLE_END |=> !done)
    else $error("flag not cleared");
  flag_kept_a: assert property ($fell(done) |->
    $past(FLAG_CLEAR) && !$past(CYCLE_END)) else $error("flag lost");
  crc_no_req_a: assert property (CRC_ERROR |->
    !$past(REQ_VALID) ##0 !REQ_VALID [*8]) else $error("bad crc issued");
  req_hold_a: assert property (REQ_VALID |=>
    ($stable(REQ_CMD) && $stable(WR_DATA)) [*8]) else $error("req moved");
  busy_wait_a: assert property (REQ_VALID |->
    BUSY throughout (##[1:1000] BACK_DONE)) else $error("idle too early");
  to_late_a: assert property (TIMEOUT_EVENT |->
    run_q + 32'h0000_0004 >= lim_q) else $error("timeout too early");
  to_bound_a: assert property (BUSY |->
    run_q <= lim_q + 32'h0000_0008) else $error("timeout missed");
  to_idle_a: assert property (TIMEOUT_EVENT |-> ##[0:2] !BUSY)
    else $error("not idle after timeout");
  cover property (REQ_VALID && REQ_CMD.write);
  cover property (REQ_VALID && !REQ_CMD.write);
  cover property (CRC_ERROR);
  cover property (TIMEOUT_EVENT);
endmodule : srp_props

bind srp_top srp_props #(.TIMEOUT_CYCLES(TIMEOUT_CYCLES)) i_srp_props (
  .CLOCK(CLOCK), .RESET_N(RESET_N), .COMM_TIMEOUT_LIMIT(COMM_TIMEOUT_LIMIT),
  .COMM_TIMEOUT_LOAD(COMM_TIMEOUT_LOAD), .REQ_VALID(REQ_VALID),
  .REQ_CMD(REQ_CMD), .WR_DATA(WR_DATA), .BACK_DONE(BACK_DONE), .BUSY(BUSY),
  .TIMEOUT_EVENT(TIMEOUT_EVENT), .CRC_ERROR(CRC_ERROR),
  .CYCLE_END(CYCLE_END), .FLAG_CLEAR(FLAG_CLEAR),
  .PROCESSING_CYCLE_DONE_FLAG(PROCESSING_CYCLE_DONE_FLAG));

/* srp_host.sv */
// host serial master model for the command link
`timescale 1ns/1ps
module srp_host (
  input  wire logic clk,
  input  wire logic miso,
  input  wire logic miso_oe,
  output logic      sclk,
  output logic      ss_n,
  output logic      mosi
);
  logic miso_w;
  // pull-up holds the data line high once the device lets go
  assign miso_w = miso_oe ? miso : 1'b1;
  initial begin
    sclk = 1'b0;
    ss_n = 1'b1;
    mosi = 1'b0;
  end
  // select stays low between commands, the device needs no toggle
  task automatic xfer(input logic [7:0] tx, output logic [7:0] rx);
    ss_n = 1'b0;
    repeat (410) @(posedge clk);
    #1;
    for (int i = 7; i >= 0; i--) begin
      mosi = tx[i];
      #62.5;
      sclk = 1'b1;
      rx[i] = miso_w;
      #62.5;
      sclk = 1'b0;
    end
    mosi = ~tx[0];
  endtask : xfer
endmodule : srp_host

/* srp_top_tb_top.sv */
// bench for the serial register protocol device end
`timescale 1ns/1ps
module srp_top_tb_top;
  localparam logic [1:0] OPW = srp_pkg::OP_WRITE;
  localparam logic [1:0] OPR = srp_pkg::OP_READ;
  logic        clock, reset_n, sclk, ss_n, mosi, miso, miso_oe, crc_en;
  logic        to_load, req_valid, back_done, rd_valid, rd_ready, busy;
  logic        to_event, crc_err, cyc_end, flag_clr, flag;
  logic [31:0] to_limit;
  logic [63:0] wr_data, got_wr, rd_src;
  logic [7:0]  rd_data, rx;
  int          fails, checks_done, reqs, crcs, tos;
  srp_pkg::srp_cmd_t req_cmd, got_cmd;

  srp_top #(.TIMEOUT_CYCLES(32'h0000_2EE0)) i_srp_top (
    .CLOCK(clock), .RESET_N(reset_n), .SCLK(sclk), .SS_N(ss_n),
    .MOSI(mosi), .MISO(miso), .MISO_OE(miso_oe),
    .CRC_CHECK_ENABLE(crc_en), .COMM_TIMEOUT_LIMIT(to_limit),
    .COMM_TIMEOUT_LOAD(to_load), .REQ_VALID(req_valid), .REQ_CMD(req_cmd),
    .WR_DATA(wr_data), .BACK_DONE(back_done), .RD_VALID(rd_valid),
    .RD_READY(rd_ready), .RD_DATA(rd_data), .BUSY(busy),
    .TIMEOUT_EVENT(to_event), .CRC_ERROR(crc_err), .CYCLE_END(cyc_end),
    .FLAG_CLEAR(flag_clr), .PROCESSING_CYCLE_DONE_FLAG(flag));
  srp_host i_srp_host (.clk(clock), .miso(miso), .miso_oe(miso_oe),
    .sclk(sclk), .ss_n(ss_n), .mosi(mosi));

  initial begin
    clock = 1'b0;
    forever #5 clock = ~clock;
  end

  task automatic chk_val(input logic [63:0] got, input logic [63:0] exp);
    checks_done++;
    if (got !== exp) begin
      fails++;
      $display("wrong value at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : chk_val

  task automatic chk_byte(input logic [7:0] got, input logic [7:0] exp);
    chk_val(64'(got), 64'(exp));
  endtask : chk_byte

  task automatic wrap_up();
    $display("checks %0d mismatches %0d", checks_done, fails);
    if (fails == 0 && checks_done > 0) $display("SIMULATION PASSED");
    else $display("SIMULATION FAILED");
    $finish;
  endtask : wrap_up

  function automatic logic [7:0] crc_upd(input logic [7:0] c,
                                         input logic [7:0] d);
    logic [7:0] r;
    r = c ^ d;
    repeat (8) r = {r[6:0], 1'b0} ^ (r[7] ? 8'h31 : 8'h00);
    return r;
  endfunction : crc_upd

  always @(posedge clock) begin
    #1;
    if (crc_err === 1'b1) crcs++;
    if (to_event === 1'b1) tos++;
  end

  // slow backend so that every live command sees at least one busy answer
  initial begin : backend
    forever begin
      @(posedge clock);
      #1;
      if (req_valid === 1'b1) begin
        reqs++;
        got_cmd = req_cmd;
        got_wr = wr_data;
        repeat (900) @(posedge clock);
        #1;
        for (int k = 0; k < (got_cmd.write ? 0 : 1 << got_cmd.len); k++) begin
          while (rd_ready !== 1'b1) begin
            @(posedge clock);
            #1;
          end
          rd_valid = 1'b1;
          rd_data = rd_src[8*k+:8];
          @(posedge clock);
          #1;
        end
        rd_valid = 1'b0;
        back_done = 1'b1;
        @(posedge clock);
        #1;
        back_done = 1'b0;
      end
    end
  end

  task automatic flag_op(input logic set, input logic clr, input logic exp);
    @(posedge clock);
    #1;
    cyc_end = set;
    flag_clr = clr;
    @(posedge clock);
    #1;
    cyc_end = 1'b0;
    flag_clr = 1'b0;
    chk_val(64'(flag), 64'(exp));
  endtask : flag_op

  task automatic txn(input logic [1:0] op, input logic [1:0] len,
                     input logic [11:0] adr, input logic [63:0] dat,
                     input logic crc_on, input logic bad);
    logic [7:0]  b;
    logic [7:0]  crc;
    logic [63:0] msk;
    logic        live;
    int          nb;
    int          naks;
    int          r0;
    nb = 1 << len;
    msk = 64'hFFFF_FFFF_FFFF_FFFF >> (64 - 8 * nb);
    live = !op[0] && !bad;
    r0 = reqs;
    rd_src = dat;
    crc_en = crc_on;
    b = {op, len, adr[11:8]};
    crc = crc_upd(crc_upd(8'h00, b), adr[7:0]);
    i_srp_host.xfer(b, rx);
    chk_byte(rx, srp_pkg::ECHO_CMD);
    i_srp_host.xfer(adr[7:0], rx);
    chk_byte(rx, srp_pkg::ECHO_ADDR);
    for (int k = 0; k < nb && op == OPW; k++) begin
      b = dat[8*k+:8];
      crc = crc_upd(crc, b);
      i_srp_host.xfer(b, rx);
      chk_byte(rx, srp_pkg::ACK);
    end
    if (crc_on && op == OPW) begin
      i_srp_host.xfer(crc ^ {7'h00, bad}, rx);
      chk_byte(rx, srp_pkg::ACK);
    end
    naks = 0;
    i_srp_host.xfer(8'hFF, rx);
    while (rx === srp_pkg::NAK && naks < 12) begin
      naks++;
      i_srp_host.xfer(8'hFF, rx);
    end
    chk_byte(rx, srp_pkg::ACK);
    chk_val(64'(naks != 0), 64'(live));
    for (int k = 0; k < nb && op == OPR; k++) begin
      b = dat[8*k+:8];
      crc = crc_upd(crc, b);
      i_srp_host.xfer(8'hFF, rx);
      chk_byte(rx, b);
    end
    if (crc_on && op == OPR) begin
      i_srp_host.xfer(8'hFF, rx);
      chk_byte(rx, crc);
    end
    chk_val(64'(reqs - r0), 64'(live));
    if (live) chk_val(64'(got_cmd), 64'({op[1], len, adr}));
    if (live && op[1]) chk_val(got_wr & msk, dat & msk);
  endtask : txn

  initial begin
    fails = 0;
    checks_done = 0;
    reqs = 0;
    crcs = 0;
    tos = 0;
    reset_n = 1'b0;
    crc_en = 1'b0;
    to_load = 1'b0;
    to_limit = 32'h0000_0000;
    back_done = 1'b0;
    rd_valid = 1'b0;
    rd_data = 8'h00;
    cyc_end = 1'b0;
    flag_clr = 1'b0;
    rd_src = 64'h0;
    repeat (4) @(posedge clock);
    #1;
    reset_n = 1'b1;
    chk_val(64'({busy, miso_oe, flag}), 64'h0);
    flag_op(1'b1, 1'b0, 1'b1);
    flag_op(1'b0, 1'b0, 1'b1);
    flag_op(1'b0, 1'b1, 1'b0);
    flag_op(1'b1, 1'b1, 1'b1);
    txn(OPW, 2'h0, 12'h5A3, 64'hC7, 1'b0, 1'b0);
    txn(OPW, 2'h3, 12'hF01, 64'h8877665544332211, 1'b1, 1'b0);
    txn(OPW, 2'h1, 12'h3C4, 64'hBEEF, 1'b1, 1'b1);
    chk_val(64'(crcs), 64'h1);
    chk_val(64'(flag), 64'h1);
    txn(OPR, 2'h2, 12'hA00, 64'hD4C3B2A1, 1'b1, 1'b0);
    flag_op(1'b0, 1'b1, 1'b0);
    txn(2'h1, 2'h0, 12'h123, 64'h0, 1'b0, 1'b0);
    @(posedge clock);
    #1;
    to_limit = 32'h0000_07D0;
    to_load = 1'b1;
    @(posedge clock);
    #1;
    to_load = 1'b0;
    i_srp_host.xfer({OPW, 2'h1, 4'h7}, rx);
    i_srp_host.xfer(8'h21, rx);
    for (int i = 0; i < 3000 && tos == 0; i++) @(posedge clock);
    #2;
    chk_val(64'(tos), 64'h1);
    chk_val(64'(busy), 64'h0);
    repeat (2100) @(posedge clock);
    #1;
    txn(2'h3, 2'h1, 12'h456, 64'h0, 1'b0, 1'b0);
    wrap_up();
  end

  initial begin
    repeat (80000) @(posedge clock);
    fails++;
    wrap_up();
  end
endmodule : srp_top_tb_top
